/* File: common/sfps_pkg.sv */
// Purpose: Shared constants, opcodes and types of the flash command sequencer
// Assumes: 100 MHz system clock
// Notes: Array timing defaults sit on the top module as parameters
package sfps_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Opcodes
  localparam logic [7:0] OPC_STAT_A = 8'h57;
  localparam logic [7:0] OPC_STAT_B = 8'hD7;
  localparam logic [7:0] OPC_BWR_1 = 8'h84;
  localparam logic [7:0] OPC_BWR_2 = 8'h87;
  localparam logic [7:0] OPC_PGE_1 = 8'h83;
  localparam logic [7:0] OPC_PGE_2 = 8'h86;
  localparam logic [7:0] OPC_PG_1 = 8'h88;
  localparam logic [7:0] OPC_PG_2 = 8'h89;
  localparam logic [7:0] OPC_PERASE = 8'h81;
  localparam logic [7:0] OPC_BERASE = 8'h50;
  localparam logic [7:0] OPC_THRU_1 = 8'h82;
  localparam logic [7:0] OPC_THRU_2 = 8'h85;

  // Frame layout, counted in serial bits
  localparam logic [5:0] OPC_LAST_BIT = 6'h07;
  localparam logic [5:0] HDR_LAST_BIT = 6'h1F;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam int unsigned HDR_OPC_MSB = 31;
  localparam int unsigned HDR_OPC_LSB = 24;
  localparam int unsigned HDR_PAGE_MSB = 19;
  localparam int unsigned HDR_PAGE_LSB = 9;
  localparam int unsigned HDR_BADDR_MSB = 8;

  // Memory geometry
  localparam int unsigned PAGE_W = 11;
  localparam int unsigned BADDR_W = 9;
  localparam int unsigned BUF_BYTES = 264;
  localparam logic [8:0] BUF_LAST = 9'h107;
  localparam logic [8:0] BUF_FIRST = 9'h000;
  localparam logic [2:0] BLK_PAGE_MASK = 3'h0;
  localparam int unsigned BLK_LOW_BITS = 3;

  // Status layout
  localparam logic [2:0] ST_RDY_IDX = 3'h7;
  localparam logic [2:0] ST_RSVD_VAL = 3'h0;

  typedef enum logic [2:0] {
    SFPS_NONE, SFPS_STAT, SFPS_BWR, SFPS_PGE, SFPS_PG, SFPS_PERASE, SFPS_BERASE, SFPS_THRU
  } sfps_op_t;

  function automatic sfps_op_t sfps_decode(input logic [7:0] opc);
    unique case (opc)
      OPC_STAT_A, OPC_STAT_B: return SFPS_STAT;
      OPC_BWR_1, OPC_BWR_2: return SFPS_BWR;
      OPC_PGE_1, OPC_PGE_2: return SFPS_PGE;
      OPC_PG_1, OPC_PG_2: return SFPS_PG;
      OPC_PERASE: return SFPS_PERASE;
      OPC_BERASE: return SFPS_BERASE;
      OPC_THRU_1, OPC_THRU_2: return SFPS_THRU;
      default: return SFPS_NONE;
    endcase
  endfunction : sfps_decode

  // Second buffer selected by these opcodes
  function automatic logic sfps_buf2(input logic [7:0] opc);
    return (opc == OPC_BWR_2) || (opc == OPC_PGE_2) || (opc == OPC_PG_2) || (opc == OPC_THRU_2);
  endfunction : sfps_buf2

  // Longest time, rounded down, never below one cycle
  function automatic logic [31:0] sfps_cycles(input int unsigned ns);
    return (ns < CLK_PERIOD_NS) ? 32'h1 : 32'(ns / CLK_PERIOD_NS);
  endfunction : sfps_cycles

endpackage : sfps_pkg

/* File: verilog/sfps_core.sv */
// Purpose: Serial command front end, page buffers and self-timed array control
// Assumes: Host drives sck_i only while cs_n_i is low; array datapath lives outside
// Notes: Serial logic runs on sck_i, timing and array handshake on mclk_i
`timescale 1ns/1ps

module sfps_core #(
  parameter int unsigned ERASE_PROG_TIME_NS = 20000000,
  parameter int unsigned PROG_TIME_NS = 14000000,
  parameter int unsigned PAGE_ERASE_TIME_NS = 8000000,
  parameter int unsigned BLOCK_ERASE_TIME_NS = 12000000,
  parameter logic [3:0] DENSITY_CODE = 4'hA // Arbitrary value
) (
  input wire logic mclk_i, // System clock
  input wire logic srst_i, // Synchronous reset, high
  input wire logic sck_i, // Serial clock from host
  input wire logic cs_n_i, // Chip select, low active
  input wire logic si_i, // Serial data in
  output logic so_o, // Serial data out
  output logic so_oe_o, // Serial out driven
  output logic busy_o, // Array operation running
  output logic arr_req_o, // Start pulse to array
  output sfps_pkg::sfps_op_t arr_op_o, // Array operation kind
  output logic [10:0] arr_page_o, // Target page
  output logic arr_buf_o, // Source buffer, 1 = second
  input wire logic arr_cmp_valid_i, // Compare result strobe
  input wire logic arr_cmp_mismatch_i, // Compare found a difference
  input wire logic arr_rd_buf_i, // Buffer read select
  input wire logic [8:0] arr_rd_addr_i, // Buffer read byte address
  output logic [7:0] arr_rd_data_o // Buffer read data
);
  import sfps_pkg::*;

  localparam logic [31:0] EP_CYC = sfps_cycles(ERASE_PROG_TIME_NS);
  localparam logic [31:0] P_CYC = sfps_cycles(PROG_TIME_NS);
  localparam logic [31:0] PE_CYC = sfps_cycles(PAGE_ERASE_TIME_NS);
  localparam logic [31:0] BE_CYC = sfps_cycles(BLOCK_ERASE_TIME_NS);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] buf_mem [0:1][0:BUF_BYTES-1];

  // Serial clock domain
  logic [5:0] bit_cnt_reg;
  logic [2:0] dbit_reg;
  logic stat_mode_reg;
  logic [31:0] hdr_reg;
  logic [6:0] dat_reg;
  logic [8:0] baddr_reg;
  logic [10:0] page_reg;
  logic [7:0] opc_reg;
  sfps_op_t op_reg;
  logic arr_pend_reg;
  logic cmp_s1_reg;
  logic cmp_s2_reg;
  logic [2:0] idx_reg;
  logic so_bit_reg;
  logic rdy_sel_reg;

  // System clock domain
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic busy_reg;
  logic [31:0] timer_reg;
  logic comp_reg;
  logic arr_req_reg;
  sfps_op_t arr_op_reg;
  logic [10:0] arr_page_reg;
  logic arr_buf_reg;
  logic [7:0] rd_data_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial decode

  wire [31:0] sh_next = {hdr_reg[30:0], si_i};
  wire [7:0] sh_opc = sh_next[HDR_OPC_MSB:HDR_OPC_LSB];
  wire sfps_op_t sh_op = sfps_decode(sh_opc);
  wire hdr_done = (bit_cnt_reg == HDR_LAST_BIT);
  wire in_header = (bit_cnt_reg < HDR_BITS);
  wire data_phase = !in_header && ((op_reg == SFPS_BWR) || (op_reg == SFPS_THRU));
  wire byte_done = (dbit_reg == 3'h7);
  wire buf_sel = sfps_buf2(opc_reg);
  wire [8:0] baddr_wrap = (baddr_reg >= BUF_LAST) ? BUF_FIRST : baddr_reg + 9'h001;
  wire is_array_op = (sh_op == SFPS_PGE) || (sh_op == SFPS_PG) || (sh_op == SFPS_PERASE)
                  || (sh_op == SFPS_BERASE) || (sh_op == SFPS_THRU);
  wire stat_start = (bit_cnt_reg == OPC_LAST_BIT)
                 && (sfps_decode(sh_next[OPC_LAST_BIT:0]) == SFPS_STAT);

  // Bit 7 is overlaid live from the busy flag; reserved bits read zero
  wire [7:0] status_vec = {1'b0, cmp_s2_reg, DENSITY_CODE, ST_RSVD_VAL[1:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Frame counters, cleared while deselected

  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      bit_cnt_reg <= 6'h00;
      dbit_reg <= 3'h0;
      stat_mode_reg <= 1'b0;
    end
    else
    begin
      if (in_header)
      begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      if (stat_start)
      begin
        stat_mode_reg <= 1'b1;
      end
      if (data_phase)
      begin
        dbit_reg <= dbit_reg + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Header capture and buffer loading on the rising serial edge

  // These hold after the frame so the system side can read them once cs_n_i is high
  always_ff @(posedge sck_i)
  begin
    if (in_header)
    begin
      hdr_reg <= sh_next;
    end
    if (bit_cnt_reg == 6'h00)
    begin
      arr_pend_reg <= 1'b0;
    end
    if (hdr_done)
    begin
      opc_reg <= sh_opc;
      op_reg <= sh_op;
      page_reg <= sh_next[HDR_PAGE_MSB:HDR_PAGE_LSB];
      baddr_reg <= sh_next[HDR_BADDR_MSB:0];
      arr_pend_reg <= is_array_op;
    end
    if (data_phase)
    begin
      dat_reg <= {dat_reg[5:0], si_i};
      if (byte_done)
      begin
        buf_mem[buf_sel][baddr_reg] <= {dat_reg, si_i};
        baddr_reg <= baddr_wrap;
      end
    end
  end

  // Compare result into the serial domain
  always_ff @(posedge sck_i)
  begin
    cmp_s1_reg <= comp_reg;
    cmp_s2_reg <= cmp_s1_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status shift-out on the falling serial edge

  always_ff @(negedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      idx_reg <= ST_RDY_IDX;
      so_bit_reg <= 1'b0;
      rdy_sel_reg <= 1'b0;
    end
    else if (stat_mode_reg)
    begin
      so_bit_reg <= status_vec[idx_reg];
      rdy_sel_reg <= (idx_reg == ST_RDY_IDX);
      idx_reg <= idx_reg - 3'h1;
    end
  end

  // Ready bit follows busy even while the serial clock is parked
  assign so_o = rdy_sel_reg ? !busy_reg : so_bit_reg;
  assign so_oe_o = !cs_n_i && stat_mode_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Deselect detection in the system domain

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
    end
    else
    begin
      cs_s1_reg <= cs_n_i;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
    end
  end

  wire frame_end = cs_s2_reg && !cs_s3_reg;
  // Header registers are static once cs_n_i is high, so they are read directly here
  wire launch = frame_end && arr_pend_reg && !busy_reg;
  wire [31:0] op_cycles = (op_reg == SFPS_PG) ? P_CYC
                        : (op_reg == SFPS_PERASE) ? PE_CYC
                        : (op_reg == SFPS_BERASE) ? BE_CYC
                        : EP_CYC;
  wire [10:0] launch_page = (op_reg == SFPS_BERASE)
                          ? {page_reg[PAGE_W-1:BLK_LOW_BITS], BLK_PAGE_MASK}
                          : page_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Self-timed array control

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      busy_reg <= 1'b0;
      timer_reg <= 32'h0;
      arr_req_reg <= 1'b0;
      arr_op_reg <= SFPS_NONE;
      arr_page_reg <= 11'h000;
      arr_buf_reg <= 1'b0;
    end
    else
    begin
      arr_req_reg <= launch;
      if (launch)
      begin
        busy_reg <= 1'b1;
        timer_reg <= op_cycles - 32'h1;
        arr_op_reg <= op_reg;
        arr_page_reg <= launch_page;
        arr_buf_reg <= buf_sel;
      end
      else if (busy_reg)
      begin
        if (timer_reg == 32'h0)
        begin
          busy_reg <= 1'b0;
        end
        else
        begin
          timer_reg <= timer_reg - 32'h1;
        end
      end
    end
  end

  // Latest compare outcome from the array side
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      comp_reg <= 1'b0;
    end
    else if (arr_cmp_valid_i)
    begin
      comp_reg <= arr_cmp_mismatch_i;
    end
  end

  // Buffer read port for the array datapath
  wire [8:0] rd_idx = (arr_rd_addr_i > BUF_LAST) ? BUF_FIRST : arr_rd_addr_i;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rd_data_reg <= 8'h00;
    end
    else
    begin
      rd_data_reg <= buf_mem[arr_rd_buf_i][rd_idx];
    end
  end

  assign busy_o = busy_reg;
  assign arr_req_o = arr_req_reg;
  assign arr_op_o = arr_op_reg;
  assign arr_page_o = arr_page_reg;
  assign arr_buf_o = arr_buf_reg;
  assign arr_rd_data_o = rd_data_reg;

endmodule : sfps_core

/* File: test/sfps_core_assertions.sv */
// Purpose: Port-level checks of the flash command sequencer
// Assumes: Times are handed over by the bind
// Notes: Busy length is counted in mclk cycles
`timescale 1ns/1ps
module sfps_core_chk
  import sfps_pkg::*;
#(
  parameter int unsigned ERASE_PROG_TIME_NS = 20000000,
  parameter int unsigned PROG_TIME_NS = 14000000,
  parameter int unsigned PAGE_ERASE_TIME_NS = 8000000,
  parameter int unsigned BLOCK_ERASE_TIME_NS = 12000000
) (
  input wire logic mclk_i, // System clock
  input wire logic srst_i, // Reset
  input wire logic cs_n_i, // Chip select
  input wire logic so_oe_o, // Serial out driven
  input wire logic busy_o, // Busy
  input wire logic arr_req_o, // Start pulse
  input wire sfps_pkg::sfps_op_t arr_op_o, // Operation
  input wire logic [10:0] arr_page_o, // Page
  input wire logic arr_buf_o // Buffer
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic [31:0] busy_len_reg;
  logic [31:0] busy_lim;
  assign busy_lim = (arr_op_o == SFPS_PG) ? PROG_TIME_NS / CLK_PERIOD_NS
    : (arr_op_o == SFPS_PERASE) ? PAGE_ERASE_TIME_NS / CLK_PERIOD_NS
    : (arr_op_o == SFPS_BERASE) ? BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS
    : ERASE_PROG_TIME_NS / CLK_PERIOD_NS;
  always_ff @(posedge mclk_i)
    if (srst_i)
      busy_len_reg <= '0;
    else if (arr_req_o)
      busy_len_reg <= 32'h1;
    else if (busy_o)
      busy_len_reg <= busy_len_reg + 32'h1;
  chk_req_busy_start: assert property (arr_req_o |-> busy_o && !$past(busy_o))
    else $error("start pulse without fresh busy");
  chk_req_single_pulse: assert property (arr_req_o |=> !arr_req_o)
    else $error("start pulse longer than one cycle");
  chk_busy_has_cause: assert property ($rose(busy_o) |-> arr_req_o)
    else $error("busy rose without start");
  chk_launch_after_deselect: assert property (arr_req_o |-> cs_n_i && $past(cs_n_i, 2))
    else $error("launch before chip select rose");
  chk_block_page_align: assert property (
    arr_req_o && arr_op_o == SFPS_BERASE |-> arr_page_o[2:0] == 3'h0)
    else $error("block erase page not aligned");
  chk_target_hold: assert property (busy_o && !arr_req_o |->
    $stable(arr_op_o) && $stable(arr_page_o) && $stable(arr_buf_o))
    else $error("target changed while busy");
  chk_busy_length: assert property ($fell(busy_o) |->
    busy_len_reg <= busy_lim && busy_len_reg + 32'h1 >= busy_lim)
    else $error("busy length wrong");
  chk_busy_min_span: assert property (arr_req_o |=> busy_o [*2])
    else $error("busy dropped early");
  chk_oe_selected: assert property (so_oe_o |-> !cs_n_i)
    else $error("serial out driven while deselected");
endmodule : sfps_core_chk
bind sfps_core sfps_core_chk #(.ERASE_PROG_TIME_NS(ERASE_PROG_TIME_NS),
  .PROG_TIME_NS(PROG_TIME_NS), .PAGE_ERASE_TIME_NS(PAGE_ERASE_TIME_NS),
  .BLOCK_ERASE_TIME_NS(BLOCK_ERASE_TIME_NS)) i_sfps_core_chk (.mclk_i(mclk_i),
  .srst_i(srst_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o), .busy_o(busy_o),
  .arr_req_o(arr_req_o), .arr_op_o(arr_op_o), .arr_page_o(arr_page_o),
  .arr_buf_o(arr_buf_o));

/* File: test/sfps_host.sv */
// Purpose: Host serial master model
// Assumes: Clock idles low, 64 ns period, only inside frames
// Notes: Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module sfps_host (
  output logic sck_o, // Serial clock
  output logic cs_n_o, // Chip select, low
  output logic si_o, // Data to device
  input wire logic so_i // Data from device
);
  initial
  begin
    sck_o = 1'b0;
    si_o = 1'b0;
    // Late rise gives the device a chip select edge that clears its serial state
    #1 cs_n_o = 1'b1;
  end
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si_o = tx[i];
      #32 sck_o = 1'b1;
      rx[i] = so_i;
      #32 sck_o = 1'b0;
    end
  endtask : xfer
  task automatic open_frame;
    cs_n_o = 1'b0;
    #32;
  endtask : open_frame
  task automatic close_frame;
    #32 cs_n_o = 1'b1;
    si_o = ~si_o;
    #200;
  endtask : close_frame
endmodule : sfps_host

/* File: test/tb.sv */
// Purpose: Self-checking bench of the flash command sequencer
// Assumes: Short array times set by parameters
// Notes: Host model drives the serial side
`timescale 1ns/1ps
module tb;
  import sfps_pkg::*;
  localparam logic [3:0] DENS = 4'h5; // Arbitrary value
  localparam logic [7:0] BUF_TAB = 8'hA2;
  logic mclk = 1'b0, srst = 1'b1, sck, cs_n, si, so, so_oe, busy, arr_req, arr_buf;
  logic cmp_valid = 1'b0, cmp_mis = 1'b0, rd_buf = 1'b0;
  logic [8:0] rd_addr = 9'h000;
  logic [7:0] rd_data, r;
  logic [10:0] arr_page, pg;
  sfps_op_t arr_op;
  int error_cnt = 0, checks_done = 0, req_cnt = 0, w;
  logic [7:0] opc_tab [8] = '{OPC_PGE_1, OPC_PGE_2, OPC_PERASE, OPC_BERASE, OPC_PG_1,
    OPC_PG_2, OPC_THRU_1, OPC_THRU_2};
  sfps_op_t op_tab [8] = '{SFPS_PGE, SFPS_PGE, SFPS_PERASE, SFPS_BERASE, SFPS_PG,
    SFPS_PG, SFPS_THRU, SFPS_THRU};
  always #5 mclk = ~mclk;
  always @(negedge mclk)
    if (arr_req === 1'b1)
      req_cnt++;
  sfps_core #(.ERASE_PROG_TIME_NS(20000), .PROG_TIME_NS(16000), .PAGE_ERASE_TIME_NS(12000),
    .BLOCK_ERASE_TIME_NS(8000), .DENSITY_CODE(DENS)) i_sfps_core (.mclk_i(mclk),
    .srst_i(srst), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .busy_o(busy), .arr_req_o(arr_req), .arr_op_o(arr_op), .arr_page_o(arr_page),
    .arr_buf_o(arr_buf), .arr_cmp_valid_i(cmp_valid), .arr_cmp_mismatch_i(cmp_mis),
    .arr_rd_buf_i(rd_buf), .arr_rd_addr_i(rd_addr), .arr_rd_data_o(rd_data));
  sfps_host i_sfps_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic frame(input logic [31:0] h, input int nd, input logic [7:0] d);
    logic [7:0] x;
    i_sfps_host.open_frame();
    for (int k = 3; k >= 0; k--)
      i_sfps_host.xfer(h[k*8 +: 8], x);
    for (int k = 0; k < nd; k++)
      i_sfps_host.xfer(8'(d + 8'h11 * k), x);
    i_sfps_host.close_frame();
    tick(1);
  endtask : frame
  task automatic stat(input logic [7:0] opc, input logic [7:0] exp);
    logic [7:0] x;
    i_sfps_host.open_frame();
    i_sfps_host.xfer(opc, x);
    for (int k = 0; k < 2; k++)
    begin
      i_sfps_host.xfer(8'h00, x);
      chk({24'h0, x & 8'hFC}, {24'h0, exp});
    end
    chk({31'h0, so_oe}, 32'h1);
    i_sfps_host.close_frame();
    chk({31'h0, so_oe}, 32'h0);
  endtask : stat
  task automatic rd_chk(input logic b, input logic [8:0] a, input logic [7:0] exp);
    rd_buf = b;
    rd_addr = a;
    tick(2);
    chk({24'h0, rd_data}, {24'h0, exp});
  endtask : rd_chk
  initial
  begin
    #400000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial
  begin
    tick(3);
    srst = 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      cmp_mis = m[0];
      cmp_valid = 1'b1;
      tick(1);
      cmp_valid = 1'b0;
      stat(OPC_STAT_A, {1'b1, m[0], DENS, 2'b00});
      stat(OPC_STAT_B, {1'b1, m[0], DENS, 2'b00});
    end
    $display("status test done");
    for (int b = 0; b < 2; b++)
    begin
      frame({b[0] ? OPC_BWR_2 : OPC_BWR_1, 15'h0, 9'h106}, 3, 8'h11);
      rd_chk(b[0], 9'h106, 8'h11);
      rd_chk(b[0], 9'h107, 8'h22);
      rd_chk(b[0], 9'h000, 8'h33);
    end
    $display("buffer write test done");
    for (int i = 0; i < 8; i++)
    begin
      pg = 11'h7FF - 11'(i);
      frame({opc_tab[i], 4'h0, pg, 9'h003}, (i > 5) ? 1 : 0, 8'h5A);
      chk({29'h0, arr_op}, {29'h0, op_tab[i]});
      chk({21'h0, arr_page}, {21'h0, (i == 3) ? {pg[10:3], 3'h0} : pg});
      chk({31'h0, arr_buf}, {31'h0, BUF_TAB[i]});
      chk({31'h0, busy}, 32'h1);
      frame({OPC_PERASE, 24'h0}, 0, 8'h00);
      i_sfps_host.open_frame();
      i_sfps_host.xfer(OPC_STAT_B, r);
      tick(1);
      chk({31'h0, so}, 32'h0);
      for (w = 0; w < 3000 && busy === 1'b1; w++)
        tick(1);
      tick(2);
      chk({31'h0, so}, 32'h1);
      chk({31'h0, busy}, 32'h0);
      i_sfps_host.close_frame();
    end
    chk(32'(req_cnt), 32'h8);
    rd_chk(1'b0, 9'h003, 8'h5A);
    rd_chk(1'b1, 9'h003, 8'h5A);
    $display("array test done");
    complete_run();
  end
endmodule : tb
